/* src/tmrwv_top.sv */
// Behaviour
// - Mode two clears counter on compare match
// - Clear-on-match compare unbuffered; late write wraps
// - Clear-on-match sets compare flag each period
// - Action one toggles output on match, except in phase mode
// - Pin driven only when direction is output
// - Clear-on-match overflow at max to zero
// - Toggle frequency clock/(2*N*(1+compare))
// - Fast mode counts bottom to max, wraps
// - Fast: clear on match, set at bottom
// - Fast bottom transition at max-to-bottom step
// - Fast overflow flag at max-to-bottom step
// - Fast period is 256 timer clocks
// - Fast extremes: spike or constant level
// - Fast toggle action keeps compare buffered
// - Mode one counts up then down
// - Phase mode holds max one cycle
// - Phase: clear on up match, set down
// - Phase overflow flag at bottom
// - Phase period is 510 timer clocks
// - Prescale is 1, 8, 64, 256, 1024
// - PWM compare updates at top only
// - Compare flag set cycle after equality
// - Compare flag cleared by writing one
`default_nettype none
module tmrwv_top
  import tmrwv_pkg::*;
(
  input  wire logic        I_CLK,      // 50 MHz clock
  input  wire logic        I_RESET_N,  // Async reset, active low
  input  wire logic [3:0]  I_ADDR,     // Register byte address
  input  wire logic [31:0] I_WDATA,    // Write data
  input  wire logic        I_WR,       // Write strobe
  input  wire logic        I_RD,       // Read strobe
  input  wire logic        I_INT_ACK,  // Compare interrupt serviced
  output logic [31:0]      O_RDATA,    // Read data, cycle after strobe
  output logic             O_PIN_OUT,  // Compare output pin level
  output logic             O_PIN_OE,   // Pin output enable
  output logic             O_OVF,      // Overflow flag
  output logic             O_CMF       // Compare match flag
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0]  wgm;       // Waveform mode select
    logic [1:0]  com;       // Output action select
    logic [2:0]  cs;        // Clock select
    logic        dir;       // Pin direction
    logic [7:0]  cnt;       // Counter value
    logic [7:0]  cmp;       // Active compare value
    logic [7:0]  cmp_buf;   // Software compare buffer
    logic        down;      // Counting down (phase mode)
    logic [9:0]  pre;       // Prescaler counter
    logic        block;     // Match blocked after counter write
    logic        match_d;   // Match seen, flag next tick
    logic        ovf;       // Overflow flag
    logic        cmf;       // Compare match flag
    logic        oc;        // Internal compare output state
    logic [31:0] rdata;     // Read data register
    logic        pin;       // Registered pin level
    logic        oe;        // Registered pin enable
  } tmrwv_state_t;

  tmrwv_state_t st;       // Current state
  tmrwv_state_t next_st;  // Next state

  // ==========================================================
  // Prescale tap: true when the prescaler permits a timer tick
  function automatic logic tick_of(input logic [2:0] cs, input logic [9:0] pre);
    case (cs)
      3'h1:    tick_of = 1'b1;
      3'h2:    tick_of = (pre[2:0] == 3'h7);
      3'h3:    tick_of = (pre[5:0] == 6'h3f);
      3'h4:    tick_of = (pre[7:0] == 8'hff);
      3'h5:    tick_of = (pre == TMRWV_PRE_MAX);
      default: tick_of = 1'b0; // Stopped; external clock not wired
    endcase
  endfunction

  // Register decode used for both strobes
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic        tick;      // Timer clock enable
    logic        eq;        // Comparator equality
    logic        match;     // Match that acts this tick
    logic        pwm;       // Either PWM mode
    logic        at_top;    // Counter at maximum of its count
    logic        force_cmp; // Forced compare strobe
    logic        ovf_hit;   // Overflow event on this tick
    next_st   = st;
    tick      = tick_of(st.cs, st.pre);
    eq        = (st.cnt == st.cmp);
    match     = eq && !st.block;
    pwm       = (st.wgm == TMRWV_PHASE) || (st.wgm == TMRWV_FAST);
    at_top    = (st.cnt == TMRWV_MAX);
    force_cmp = 1'b0;
    // Overflow event this tick; a flag clear in the same cycle must lose to it,
    // so the event is worked out once here rather than guessed from next_st
    ovf_hit   = tick && (at_top ? (st.wgm != TMRWV_PHASE) :
                (st.wgm == TMRWV_PHASE && st.down && st.cnt == TMRWV_BOTTOM + 8'h01));
    next_st.pre = st.pre + 10'h001;

    if (tick) begin
      next_st.block   = 1'b0;
      next_st.match_d = match;
      if (st.match_d && (st.wgm == TMRWV_CLEAR_ON_MATCH || st.wgm == TMRWV_NORMAL ||
          pwm)) begin
        next_st.cmf = 1'b1;
      end
      case (tmrwv_mode_t'(st.wgm))
        TMRWV_CLEAR_ON_MATCH: begin
          // Compare is the top; missed match runs to 0xff and wraps
          if (eq) begin
            next_st.cnt = TMRWV_BOTTOM;
          end else begin
            next_st.cnt = st.cnt + 8'h01;
          end
          // Max to zero sets the flag even when the compare value is 0xff
          if (at_top) begin
            next_st.ovf = 1'b1;
          end
        end
        TMRWV_FAST: begin
          next_st.cnt = st.cnt + 8'h01;
          if (at_top) begin
            next_st.ovf = 1'b1;
            next_st.cmp = st.cmp_buf;
          end
        end
        TMRWV_PHASE: begin
          // Max is held one tick, then direction turns
          if (!st.down) begin
            if (at_top) begin
              next_st.down = 1'b1;
              next_st.cnt  = st.cnt - 8'h01;
              next_st.cmp  = st.cmp_buf;
            end else begin
              next_st.cnt = st.cnt + 8'h01;
            end
          end else if (st.cnt == TMRWV_BOTTOM + 8'h01) begin
            next_st.cnt  = TMRWV_BOTTOM;
            next_st.down = 1'b0;
            next_st.ovf  = 1'b1;
          end else begin
            next_st.cnt = st.cnt - 8'h01;
          end
        end
        default: begin
          next_st.cnt = st.cnt + 8'h01; // Normal mode wraps freely
          if (at_top) begin
            next_st.ovf = 1'b1;
          end
        end
      endcase

      // Waveform generator
      case (tmrwv_mode_t'(st.wgm))
        TMRWV_FAST: begin
          if (st.com == 2'h1 && match) begin
            next_st.oc = !st.oc;
          end else if (st.com[1]) begin
            if (at_top) begin
              next_st.oc = !st.com[0];
            end else if (match) begin
              next_st.oc = st.com[0];
            end
          end
        end
        TMRWV_PHASE: begin
          if (st.com[1] && match) begin
            next_st.oc = st.down ? !st.com[0] : st.com[0];
          end
        end
        default: begin
          if (match) begin
            case (st.com)
              2'h1:    next_st.oc = !st.oc;
              2'h2:    next_st.oc = 1'b0;
              2'h3:    next_st.oc = 1'b1;
              default: next_st.oc = st.oc;
            endcase
          end
        end
      endcase
    end

    // Bus writes; hardware set wins over software clear
    if (I_WR) begin
      if (hit(I_ADDR, TMRWV_ADDR_CTRL)) begin
        next_st.wgm = I_WDATA[TMRWV_WGM_LSB +: 2];
        next_st.com = I_WDATA[TMRWV_COM_LSB +: 2];
        next_st.cs  = I_WDATA[TMRWV_CS_LSB +: 3];
        next_st.dir = I_WDATA[TMRWV_DIR_BIT];
        force_cmp   = I_WDATA[TMRWV_FOC_BIT] && !pwm;
      end
      if (hit(I_ADDR, TMRWV_ADDR_COUNT)) begin
        next_st.cnt   = I_WDATA[7:0];
        next_st.block = 1'b1;
      end
      if (hit(I_ADDR, TMRWV_ADDR_CMP)) begin
        next_st.cmp_buf = I_WDATA[7:0];
        if (!pwm) begin
          next_st.cmp = I_WDATA[7:0];
        end
      end
      if (hit(I_ADDR, TMRWV_ADDR_FLAGS)) begin
        if (I_WDATA[TMRWV_CMF_BIT] && !(tick && st.match_d)) begin
          next_st.cmf = 1'b0;
        end
        if (I_WDATA[TMRWV_OVF_BIT] && !ovf_hit) begin
          next_st.ovf = 1'b0;
        end
      end
    end
    if (I_INT_ACK && !(tick && st.match_d)) begin
      next_st.cmf = 1'b0;
    end
    if (force_cmp) begin
      case (st.com)
        2'h1:    next_st.oc = !st.oc;
        2'h2:    next_st.oc = 1'b0;
        2'h3:    next_st.oc = 1'b1;
        default: next_st.oc = st.oc;
      endcase
    end

    // Read data, valid the cycle after the strobe only
    next_st.rdata = 32'h0;
    if (I_RD) begin
      if (hit(I_ADDR, TMRWV_ADDR_CTRL)) begin
        next_st.rdata = {23'h0, st.dir, 1'b0, st.cs, st.com, st.wgm};
      end else if (hit(I_ADDR, TMRWV_ADDR_COUNT)) begin
        next_st.rdata = {24'h0, st.cnt};
      end else if (hit(I_ADDR, TMRWV_ADDR_CMP)) begin
        next_st.rdata = {24'h0, st.cmp_buf};
      end else if (hit(I_ADDR, TMRWV_ADDR_FLAGS)) begin
        next_st.rdata = {30'h0, st.cmf, st.ovf};
      end
    end

    // Pin: output state overrides port only when action nonzero and dir set
    next_st.oe  = st.dir && (st.com != 2'h0);
    next_st.pin = next_st.oe ? next_st.oc : 1'b0;
  end

  // ==========================================================
  // State register
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign O_RDATA   = st.rdata;
  assign O_PIN_OUT = st.pin;
  assign O_PIN_OE  = st.oe;
  assign O_OVF     = st.ovf;
  assign O_CMF     = st.cmf;

  // ==========================================================
  // Assertions
  logic tk; // Timer tick seen by checks
  assign tk = tick_of(st.cs, st.pre);

  ctc_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    tk && st.wgm == 2'h2 && st.cnt == st.cmp && !I_WR |=> st.cnt == 8'h00)
    else $error("clear-on-match did not clear");
  ctc_wrap_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    tk && st.wgm == 2'h2 && st.cnt == 8'hff && st.cmp != 8'hff && !I_WR |=> st.cnt == 8'h00)
    else $error("clear-on-match did not wrap");
  cmf_set_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    tk && st.match_d |=> st.cmf)
    else $error("compare flag not set");
  fast_ovf_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    tk && st.wgm == 2'h3 && st.cnt == 8'hff |=> st.ovf)
    else $error("fast overflow missing");
  phase_top_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    tk && st.wgm == 2'h1 && !st.down && st.cnt == 8'hff && !I_WR |=> st.down && st.cnt == 8'hfe)
    else $error("phase max not held once");
  phase_ovf_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    tk && st.wgm == 2'h1 && st.down && st.cnt == 8'h01 && !I_WR |=> st.ovf && st.cnt == 8'h00)
    else $error("phase overflow missing");
  pin_gate_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    !st.dir |=> !O_PIN_OE && !O_PIN_OUT)
    else $error("pin driven while input");
  fast_set_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    tk && st.wgm == 2'h3 && st.com == 2'h2 && st.cnt == 8'hff && !I_WR |=> st.oc)
    else $error("fast output not set at bottom");
  buf_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    st.wgm == 2'h3 && !(tk && st.cnt == 8'hff) && !I_WR |=> $stable(st.cmp))
    else $error("compare changed mid period");


  // ==========================================================
  // Mode-specific waveform and flag checks
  // Antecedents except ctc_ovf_a, cmf_ack_a and pin_drive_a exclude bus writes, which may legally reshape the step
  ctc_ovf_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    tk && st.wgm == 2'h2 && st.cnt == 8'hff |=> st.ovf)
    else $error("clear-on-match overflow missing");
  ctc_toggle_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    tk && st.wgm == 2'h2 && st.com == 2'h1 && st.cnt == st.cmp && !st.block && !I_WR
    |=> st.oc != $past(st.oc))
    else $error("clear-on-match output not toggled");
  fast_wrap_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    tk && st.wgm == 2'h3 && st.cnt == 8'hff && !I_WR |=> st.cnt == 8'h00)
    else $error("fast counter did not wrap");
  fast_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    tk && st.wgm == 2'h3 && st.com == 2'h2 && st.cnt == st.cmp && st.cnt != 8'hff &&
    !st.block && !I_WR |=> !st.oc)
    else $error("fast output not cleared on match");
  phase_clr_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    tk && st.wgm == 2'h1 && st.com == 2'h2 && !st.down && st.cnt == st.cmp &&
    !st.block && !I_WR |=> !st.oc)
    else $error("phase output not cleared going up");
  phase_set_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    tk && st.wgm == 2'h1 && st.com == 2'h2 && st.down && st.cnt == st.cmp &&
    !st.block && !I_WR |=> st.oc)
    else $error("phase output not set going down");
  cmf_ack_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_INT_ACK && !(tk && st.match_d) |=> !st.cmf)
    else $error("compare flag not cleared by service");
  pin_drive_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    st.dir && st.com != 2'h0 |=> O_PIN_OE)
    else $error("pin not driven while output");

  // Main scenarios to be seen at least once
  ctc_cov: cover property (@(posedge I_CLK) tk && st.wgm == 2'h2 && st.cnt == st.cmp);
  fast_cov: cover property (@(posedge I_CLK) tk && st.wgm == 2'h3 && st.cnt == 8'hff);
  phase_cov: cover property (@(posedge I_CLK) tk && st.wgm == 2'h1 && st.down);
  clr_cov: cover property (@(posedge I_CLK) st.cmf ##1 !st.cmf);

endmodule // tmrwv_top
`default_nettype wire

/* inc/tmrwv_pkg.sv */
`default_nettype none
package tmrwv_pkg;
  // ==========================================================
  // Register map (word index = byte address / 4)
  localparam logic [3:0] TMRWV_ADDR_CTRL   = 4'h0; // Mode, action, clock select, force
  localparam logic [3:0] TMRWV_ADDR_COUNT  = 4'h4; // Counter value
  localparam logic [3:0] TMRWV_ADDR_CMP    = 4'h8; // Compare value (buffer in PWM)
  localparam logic [3:0] TMRWV_ADDR_FLAGS  = 4'hc; // Flags, write one to clear

  // ==========================================================
  // Control field positions
  localparam int TMRWV_WGM_LSB = 0;  // Waveform mode select [1:0]
  localparam int TMRWV_COM_LSB = 2;  // Output action select [3:2]
  localparam int TMRWV_CS_LSB  = 4;  // Clock select [6:4]
  localparam int TMRWV_FOC_BIT = 7;  // Force compare strobe
  localparam int TMRWV_DIR_BIT = 8;  // Pin direction, 1 = output
  localparam int TMRWV_OVF_BIT = 0;  // Overflow flag position
  localparam int TMRWV_CMF_BIT = 1;  // Compare match flag position

  // ==========================================================
  // Counter constants and reset values
  localparam logic [7:0]  TMRWV_BOTTOM   = 8'h00; // Bottom of the count
  localparam logic [7:0]  TMRWV_MAX      = 8'hff; // Maximum of the count
  localparam logic [9:0]  TMRWV_PRE_MAX  = 10'h3ff; // Largest prescale count
  localparam logic [31:0] TMRWV_CTRL_RST = 32'h0; // Control after reset

  // Waveform modes
  typedef enum logic [1:0] {
    TMRWV_NORMAL, TMRWV_PHASE, TMRWV_CLEAR_ON_MATCH, TMRWV_FAST
  } tmrwv_mode_t;

  // Register bus request
  typedef struct packed {
    logic [3:0]  addr;  // Byte address
    logic [31:0] wdata; // Write data
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
  } tmrwv_bus_t;
endpackage
`default_nettype wire

/* tb/tmrwv_top_tb.sv */
`default_nettype none
module tmrwv_top_tb
  import tmrwv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Bench signals
  logic        clk       = 1'b0;  // 50 MHz clock
  logic        rst_n     = 1'b0;  // Reset, active low
  logic [3:0]  addr      = 4'h0;  // Bus address
  logic [31:0] wdata     = 32'h0; // Bus write data
  logic        wr        = 1'b0;  // Write strobe
  logic        rd        = 1'b0;  // Read strobe
  logic        ack       = 1'b0;  // Interrupt serviced pulse
  logic [31:0] rdata;             // Read data
  logic        pin;               // Pin level
  logic        oe;                // Pin enable
  logic        ovf;               // Overflow flag
  logic        cmf;               // Compare flag
  int          failures  = 0;     // Mismatch count
  int          cmp_count = 0;     // Comparison count
  int          cyc       = 0;     // Cycle counter
  int          hi;                // Measured high time
  int          per;               // Measured period
  logic [31:0] rv;                // Read result

  always #10 clk = ~clk;

  tmrwv_top u_dut (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .I_INT_ACK(ack), .O_RDATA(rdata), .O_PIN_OUT(pin), .O_PIN_OE(oe), .O_OVF(ovf), .O_CMF(cmf)
  );

  // ==========================================================
  // Helpers
  // Timeout guard; the whole run needs about 20k cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write; ends just past the edge so flags have settled
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic [31:0] cfg(input logic [1:0] m, input logic [1:0] a,
                                      input logic [2:0] cs, input logic d);
    return {23'h0, d, 1'b0, cs, a, m};
  endfunction

  // Bounded wait on pin (0), overflow (1) or compare flag (2)
  task automatic wait_sig(input int sel, input logic v);
    int n;
    n = 0;
    while (((sel == 0) ? pin : (sel == 1) ? ovf : cmf) !== v && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // High time and period of the pin, in clocks
  task automatic pin_gap(output int h, output int p);
    int t0;
    int t1;
    wait_sig(0, 1'b0);
    wait_sig(0, 1'b1);
    t0 = cyc;
    wait_sig(0, 1'b0);
    t1 = cyc;
    wait_sig(0, 1'b1);
    h = t1 - t0;
    p = cyc - t0;
  endtask

  // Spacing of two flag rises; a stale flag is cleared first so t0 is a real rise
  task automatic flag_gap(input int sel, output int g);
    int t0;
    wait_sig(sel, 1'b1);
    bus_wr(TMRWV_ADDR_FLAGS, (sel == 1) ? 32'h1 : 32'h2);
    wait_sig(sel, 1'b1);
    t0 = cyc;
    bus_wr(TMRWV_ADDR_FLAGS, (sel == 1) ? 32'h1 : 32'h2);
    wait_sig(sel, 1'b0);
    wait_sig(sel, 1'b1);
    g = cyc - t0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    bus_rd(TMRWV_ADDR_CTRL, rv);
    check("ctrl", rv, TMRWV_CTRL_RST);
    bus_rd(TMRWV_ADDR_FLAGS, rv);
    check("flags", rv, 32'h0);
    bus_rd(4'h1, rv);
    check("unmapped", rv, 32'h0);
    check("oe idle", {31'h0, oe}, 32'h0);
  endtask

  task automatic t_ctc();
    bus_wr(TMRWV_ADDR_CMP, 32'h3);
    bus_wr(TMRWV_ADDR_CTRL, cfg(2'h2, 2'h1, 3'h1, 1'b1));
    pin_gap(hi, per);
    check("ctc half", hi, 32'h4);
    check("ctc period", per, 32'h8);
    flag_gap(2, per);
    check("ctc match gap", per, 32'h4);
    check("ctc no ovf", {31'h0, ovf}, 32'h0);
    bus_wr(TMRWV_ADDR_CTRL, cfg(2'h2, 2'h1, 3'h1, 1'b0));
    repeat (6) @(posedge clk);
    #1;
    check("oe off", {31'h0, oe}, 32'h0);
    check("pin off", {31'h0, pin}, 32'h0);
  endtask

  // Late write below the count forces a wrap before the next match
  task automatic t_late();
    int t0;
    bus_wr(TMRWV_ADDR_CMP, 32'h40);
    bus_wr(TMRWV_ADDR_CTRL, cfg(2'h2, 2'h1, 3'h1, 1'b1));
    bus_wr(TMRWV_ADDR_FLAGS, 32'h3);
    wait_sig(2, 1'b1);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    #1;
    check("ack clears", {31'h0, cmf}, 32'h0);
    repeat (40) @(posedge clk);
    bus_wr(TMRWV_ADDR_CMP, 32'h10);
    t0 = cyc;
    wait_sig(2, 1'b1);
    check("wrap wait", {31'h0, (cyc - t0 > 200) && (cyc - t0 < 300)}, 32'h1);
    check("wrap ovf", {31'h0, ovf}, 32'h1);
    bus_wr(TMRWV_ADDR_CMP, 32'hff);
    flag_gap(1, per);
    check("ctc ovf gap", per, 32'h100);
  endtask

  task automatic t_prescale();
    int n [5] = '{1, 8, 64, 256, 1024};
    bus_wr(TMRWV_ADDR_CMP, 32'h0);
    for (int i = 0; i < 5; i++) begin
      bus_wr(TMRWV_ADDR_CTRL, cfg(2'h2, 2'h1, 3'(i + 1), 1'b1));
      pin_gap(hi, per);
      pin_gap(hi, per);
      check("prescale half", hi, n[i]);
    end
  endtask

  task automatic t_fast();
    bus_wr(TMRWV_ADDR_CMP, 32'h40);
    bus_wr(TMRWV_ADDR_CTRL, cfg(2'h3, 2'h2, 3'h1, 1'b1));
    pin_gap(hi, per);
    pin_gap(hi, per);
    check("fast high", hi, 32'h41);
    check("fast period", per, 32'h100);
    flag_gap(1, per);
    check("fast ovf gap", per, 32'h100);
    bus_wr(TMRWV_ADDR_CTRL, cfg(2'h3, 2'h3, 3'h1, 1'b1));
    pin_gap(hi, per);
    pin_gap(hi, per);
    check("fast inv high", hi, 32'hbf);
    bus_wr(TMRWV_ADDR_CTRL, cfg(2'h3, 2'h1, 3'h1, 1'b1));
    pin_gap(hi, per);
    pin_gap(hi, per);
    check("fast toggle", per, 32'h200);
    bus_wr(TMRWV_ADDR_CTRL, cfg(2'h3, 2'h2, 3'h1, 1'b1));
    bus_wr(TMRWV_ADDR_CMP, 32'h0);
    pin_gap(hi, per);
    pin_gap(hi, per);
    check("fast spike", hi, 32'h1);
    bus_wr(TMRWV_ADDR_CMP, 32'hff);
    repeat (600) @(posedge clk);
    hi = 0;
    repeat (300) begin
      @(posedge clk);
      #1 hi += (pin !== 1'b1);
    end
    check("fast at max", hi, 32'h0);
  endtask

  task automatic t_phase();
    bus_wr(TMRWV_ADDR_CMP, 32'h40);
    bus_wr(TMRWV_ADDR_CTRL, cfg(2'h1, 2'h2, 3'h1, 1'b1));
    pin_gap(hi, per);
    pin_gap(hi, per);
    check("phase high", hi, 32'h80);
    check("phase period", per, 32'h1fe);
    flag_gap(1, per);
    check("phase ovf gap", per, 32'h1fe);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ctc();
    t_late();
    t_prescale();
    t_fast();
    t_phase();
    summarize();
  end
endmodule // tmrwv_top_tb
`default_nettype wire
